// File: core/gain_switch_pkg.sv
/*
  constants for the servo gain switch select block: register map,
  field positions, write range limits, mode codes and timing counts.
  assumes a 125 MHz control clock and an axi4-lite register bus.
*/
package gain_switch_pkg;

  localparam int          CLK_HZ           = 125_000_000;
  localparam int          TICK_US          = 100;
  localparam int          TICK_CYCLES      = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [15:0] DELAY_MAX        = 16'h2710;
  localparam logic [15:0] LEVEL_MAX        = 16'h4e20;

  localparam logic [7:0] OFF_CTRL          = 8'h00;
  localparam logic [7:0] OFF_POS_MODE      = 8'h04;
  localparam logic [7:0] OFF_POS_DELAY     = 8'h08;
  localparam logic [7:0] OFF_POS_LEVEL     = 8'h0c;
  localparam logic [7:0] OFF_POS_HYST      = 8'h10;
  localparam logic [7:0] OFF_RAMP_TIME     = 8'h14;
  localparam logic [7:0] OFF_VEL_MODE      = 8'h18;
  localparam logic [7:0] OFF_VEL_DELAY     = 8'h1c;
  localparam logic [7:0] OFF_VEL_LEVEL     = 8'h20;
  localparam logic [7:0] OFF_VEL_HYST      = 8'h24;
  localparam logic [7:0] OFF_TRQ_MODE      = 8'h28;
  localparam logic [7:0] OFF_TRQ_DELAY     = 8'h2c;
  localparam logic [7:0] OFF_TRQ_LEVEL     = 8'h30;
  localparam logic [7:0] OFF_TRQ_HYST      = 8'h34;
  localparam logic [7:0] OFF_STATUS        = 8'h38;

  localparam int          CTRL_ENABLE_BIT  = 0;
  localparam int          ST_SECOND_BIT    = 0;
  localparam int          ST_P_ACTION_BIT  = 1;
  localparam int          ST_RAMP_BIT      = 2;
  localparam int          ST_LOOP_LSB      = 4;
  localparam logic [15:0] RAMP_FULL        = 16'hffff;

  localparam logic [3:0] POS_MODE_MAX      = 4'ha;
  localparam logic [3:0] VEL_MODE_MAX      = 4'h5;
  localparam logic [3:0] TRQ_MODE_MAX      = 4'h3;

  localparam logic [3:0] M_FIX_FIRST       = 4'h0;
  localparam logic [3:0] M_FIX_SECOND      = 4'h1;
  localparam logic [3:0] M_HOST            = 4'h2;
  localparam logic [3:0] M_TORQUE          = 4'h3;
  localparam logic [3:0] M_VEL_VAR         = 4'h4;
  localparam logic [3:0] M_VEL_CMD         = 4'h5;
  localparam logic [3:0] M_POS_DEV         = 4'h6;
  localparam logic [3:0] M_POS_CMD         = 4'h7;
  localparam logic [3:0] M_NOT_INPOS       = 4'h8;
  localparam logic [3:0] M_ACT_SPEED       = 4'h9;
  localparam logic [3:0] M_CMD_SPEED       = 4'ha;

  typedef enum logic [1:0] {LOOP_POS, LOOP_VEL, LOOP_TRQ, LOOP_CLOSED} loop_t;

endpackage

// File: core/trigger_hysteresis.sv
/*
  one magnitude/flag trigger with hysteresis and return delay.
  assumes a one-cycle tick every 0.1 ms and a qualified value.
*/
`timescale 1ns/1ps
`default_nettype none
module trigger_hysteresis
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic        force_first,
  input  wire logic        magnitude,
  input  wire logic [31:0] value,
  input  wire logic        flag,
  input  wire logic [15:0] level,
  input  wire logic [15:0] hyst,
  input  wire logic [15:0] delay,
  output logic             second
);

  typedef struct packed
  {
    logic        second;
    logic [15:0] count;
  } state_t;

  state_t      st;
  state_t      next_st;
  logic [15:0] eff_hyst;
  logic [32:0] upper;
  logic [32:0] lower;
  logic        rise;
  logic        fall;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    eff_hyst = (level < hyst) ? level : hyst;
    upper    = {17'h0_0000, level} + {17'h0_0000, eff_hyst};
    lower    = {17'h0_0000, level} - {17'h0_0000, eff_hyst};
    // non-magnitude triggers use flag; residual deviation handled by in-position flag source
    rise     = magnitude ? ({1'b0, value} > upper) : flag;
    fall     = magnitude ? ({1'b0, value} < lower) : !flag;
    next_st  = st;
    if (force_first)
    begin
      next_st.second = 1'b0;
      next_st.count  = 16'h0000;
    end
    else if (!st.second)
    begin
      next_st.count = 16'h0000;
      if (rise)
        next_st.second = 1'b1;
    end
    else if (!fall)
      next_st.count = 16'h0000;
    // the first tick is partial, so one extra tick keeps the wait at least delay long
    else if (delay == 16'h0000 || st.count > delay)
    begin
      next_st.second = 1'b0;
      next_st.count  = 16'h0000;
    end
    else if (tick)
      next_st.count = st.count + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign second = st.second;

  a_return_needs_fall : assert property (@(posedge aclk) disable iff (!aresetn)
    st.second && !next_st.second && !force_first |-> fall && (delay == 16'h0000 || st.count > delay))
    else $error("gain returned without full qualifying delay");

endmodule
`default_nettype wire

// File: core/servo_gain_switch_select.sv
/*
  servo gain switch select: picks first or second gain set per control
  loop, velocity pi/p action in fixed mode, and position gain ramp.
  assumes synchronous inputs on aclk and an axi4-lite master.
*/
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module servo_gain_switch_select
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  control_loop,
  input  wire logic        host_gain_select_bit,
  input  wire logic [31:0] torque_cmd_abs,
  input  wire logic [31:0] vel_cmd_abs,
  input  wire logic [31:0] vel_cmd_var_abs,
  input  wire logic [31:0] pos_dev_abs,
  input  wire logic [31:0] actual_speed_abs,
  input  wire logic        pos_cmd_nonzero,
  input  wire logic        in_position,
  output logic             use_second_gain,
  output logic             vel_p_action,
  output logic [15:0]      pos_gain_blend
);

  typedef struct packed
  {
    logic        enable;
    logic [3:0]  pos_mode;
    logic [15:0] pos_delay;
    logic [15:0] pos_level;
    logic [15:0] pos_hyst;
    logic [15:0] ramp_time;
    logic [3:0]  vel_mode;
    logic [15:0] vel_delay;
    logic [15:0] vel_level;
    logic [15:0] vel_hyst;
    logic [3:0]  trq_mode;
    logic [15:0] trq_delay;
    logic [15:0] trq_level;
    logic [15:0] trq_hyst;
    logic        aw_done;
    logic        w_done;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic [16:0] tick_cnt;
    logic        second;
    logic [15:0] blend;
    logic [15:0] ramp_cnt;
  } state_t;

  state_t      st;
  state_t      next_st;
  logic        tick;
  logic        pos_sel;
  logic        vel_sel;
  logic        trq_sel;
  logic        pos_trig;
  logic        vel_trig;
  logic        trq_trig;
  logic        pos_mag;
  logic [31:0] pos_value;
  logic        pos_flag;
  logic [31:0] vel_value;
  logic        pos_force;
  logic        vel_force;
  logic        trq_force;
  logic        is_pos;
  logic        target;
  logic        wr_ok;

  // a mode write outside the accepted range is refused and slverr answered
  function automatic logic reg_write_ok(input logic [7:0] addr, input logic [31:0] d);
    logic ok;
    ok = 1'b1;
    if (addr == gain_switch_pkg::OFF_POS_MODE)
      ok = d <= 32'(gain_switch_pkg::POS_MODE_MAX);
    else if (addr == gain_switch_pkg::OFF_VEL_MODE)
      ok = d <= 32'(gain_switch_pkg::VEL_MODE_MAX);
    else if (addr == gain_switch_pkg::OFF_TRQ_MODE)
      ok = d <= 32'(gain_switch_pkg::TRQ_MODE_MAX);
    else if (addr == gain_switch_pkg::OFF_POS_DELAY || addr == gain_switch_pkg::OFF_VEL_DELAY ||
             addr == gain_switch_pkg::OFF_TRQ_DELAY || addr == gain_switch_pkg::OFF_RAMP_TIME)
      ok = d <= 32'(gain_switch_pkg::DELAY_MAX);
    else if (addr == gain_switch_pkg::OFF_POS_LEVEL || addr == gain_switch_pkg::OFF_POS_HYST ||
             addr == gain_switch_pkg::OFF_VEL_LEVEL || addr == gain_switch_pkg::OFF_VEL_HYST ||
             addr == gain_switch_pkg::OFF_TRQ_LEVEL || addr == gain_switch_pkg::OFF_TRQ_HYST)
      ok = d <= 32'(gain_switch_pkg::LEVEL_MAX);
    else if (addr == gain_switch_pkg::OFF_CTRL)
      ok = 1'b1;
    else
      ok = 1'b0;
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // trigger qualification per loop
  always_comb
  begin
    is_pos    = (control_loop == gain_switch_pkg::LOOP_POS) || (control_loop == gain_switch_pkg::LOOP_CLOSED);
    pos_mag   = 1'b1;
    pos_flag  = 1'b0;
    pos_value = 32'h0000_0000;
    // deviation counts arrive already in the loop's own units
    unique case (st.pos_mode)
      gain_switch_pkg::M_TORQUE:    pos_value = torque_cmd_abs;
      gain_switch_pkg::M_VEL_CMD:   pos_value = vel_cmd_abs;
      gain_switch_pkg::M_POS_DEV:   pos_value = pos_dev_abs;
      gain_switch_pkg::M_ACT_SPEED: pos_value = actual_speed_abs;
      gain_switch_pkg::M_CMD_SPEED: pos_value = actual_speed_abs;
      gain_switch_pkg::M_POS_CMD:
      begin
        pos_mag  = 1'b0;
        pos_flag = pos_cmd_nonzero;
      end
      gain_switch_pkg::M_NOT_INPOS:
      begin
        pos_mag  = 1'b0;
        pos_flag = !in_position;
      end
      default:
      begin
        pos_mag  = 1'b0;
        pos_flag = 1'b0;
      end
    endcase
    // mode 10: command present also holds second gain
    if (st.pos_mode == gain_switch_pkg::M_CMD_SPEED && pos_cmd_nonzero)
      pos_value = 32'hffff_ffff;
    pos_force = !is_pos || !(st.pos_mode inside {4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha});
    vel_value = (st.vel_mode == gain_switch_pkg::M_VEL_VAR) ? vel_cmd_var_abs :
                (st.vel_mode == gain_switch_pkg::M_VEL_CMD) ? vel_cmd_abs : torque_cmd_abs;
    vel_force = control_loop != gain_switch_pkg::LOOP_VEL || st.vel_mode < gain_switch_pkg::M_TORQUE;
    trq_force = control_loop != gain_switch_pkg::LOOP_TRQ || st.trq_mode != gain_switch_pkg::M_TORQUE;
  end

  trigger_hysteresis u_pos
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .tick        (tick),
    .force_first (pos_force),
    .magnitude   (pos_mag),
    .value       (pos_value),
    .flag        (pos_flag),
    .level       (st.pos_level),
    .hyst        (st.pos_hyst),
    .delay       (st.pos_delay),
    .second      (pos_trig)
  );

  trigger_hysteresis u_vel
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .tick        (tick),
    .force_first (vel_force),
    .magnitude   (1'b1),
    .value       (vel_value),
    .flag        (1'b0),
    .level       (st.vel_level),
    .hyst        (st.vel_hyst),
    .delay       (st.vel_delay),
    .second      (vel_trig)
  );

  trigger_hysteresis u_trq
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .tick        (tick),
    .force_first (trq_force),
    .magnitude   (1'b1),
    .value       (torque_cmd_abs),
    .flag        (1'b0),
    .level       (st.trq_level),
    .hyst        (st.trq_hyst),
    .delay       (st.trq_delay),
    .second      (trq_trig)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic mode_select(input logic [3:0] mode, input logic host, input logic trig);
    logic r;
    r = trig;
    if (mode == gain_switch_pkg::M_FIX_FIRST)
      r = 1'b0;
    else if (mode == gain_switch_pkg::M_FIX_SECOND)
      r = 1'b1;
    else if (mode == gain_switch_pkg::M_HOST)
      r = host;
    return r;
  endfunction

  always_comb
  begin
    tick    = st.tick_cnt == 17'(gain_switch_pkg::TICK_CYCLES - 1);
    pos_sel = mode_select(st.pos_mode, host_gain_select_bit, pos_trig && !pos_force);
    vel_sel = mode_select(st.vel_mode, host_gain_select_bit, vel_trig && !vel_force);
    trq_sel = mode_select(st.trq_mode, host_gain_select_bit, trq_trig && !trq_force);
    unique case (control_loop)
      gain_switch_pkg::LOOP_VEL: target = vel_sel;
      gain_switch_pkg::LOOP_TRQ: target = trq_sel;
      default:                   target = pos_sel;
    endcase
    if (!st.enable)
      target = 1'b0;
    wr_ok   = reg_write_ok(st.aw_addr, st.w_data);
    next_st = st;
    next_st.tick_cnt = tick ? 17'h0_0000 : st.tick_cnt + 17'h0_0001;
    next_st.second   = target;
    // ramp only on the way up; dropping the gain is immediate
    if (!target)
    begin
      next_st.blend    = 16'h0000;
      next_st.ramp_cnt = 16'h0000;
    end
    else if (st.ramp_time == 16'h0000 || st.ramp_cnt >= st.ramp_time)
      next_st.blend = gain_switch_pkg::RAMP_FULL;
    else if (tick)
    begin
      next_st.ramp_cnt = st.ramp_cnt + 16'h0001;
      next_st.blend    = 16'((32'(st.ramp_cnt) + 32'h1) * 32'hffff / 32'(st.ramp_time));
    end
    // axi write channel
    if (s_axi_awvalid && !st.aw_done)
    begin
      next_st.aw_done = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_done)
    begin
      next_st.w_done = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.aw_done && st.w_done && !st.bvalid)
    begin
      next_st.bvalid  = 1'b1;
      next_st.aw_done = 1'b0;
      next_st.w_done  = 1'b0;
      next_st.bresp   = wr_ok ? 2'b00 : 2'b10;
      if (wr_ok && st.w_strb[1:0] == 2'b11)
      begin
        if (st.aw_addr == gain_switch_pkg::OFF_CTRL)      next_st.enable    = st.w_data[gain_switch_pkg::CTRL_ENABLE_BIT];
        if (st.aw_addr == gain_switch_pkg::OFF_POS_MODE)  next_st.pos_mode  = st.w_data[3:0];
        if (st.aw_addr == gain_switch_pkg::OFF_POS_DELAY) next_st.pos_delay = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_POS_LEVEL) next_st.pos_level = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_POS_HYST)  next_st.pos_hyst  = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_RAMP_TIME) next_st.ramp_time = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_VEL_MODE)  next_st.vel_mode  = st.w_data[3:0];
        if (st.aw_addr == gain_switch_pkg::OFF_VEL_DELAY) next_st.vel_delay = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_VEL_LEVEL) next_st.vel_level = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_VEL_HYST)  next_st.vel_hyst  = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_TRQ_MODE)  next_st.trq_mode  = st.w_data[3:0];
        if (st.aw_addr == gain_switch_pkg::OFF_TRQ_DELAY) next_st.trq_delay = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_TRQ_LEVEL) next_st.trq_level = st.w_data[15:0];
        if (st.aw_addr == gain_switch_pkg::OFF_TRQ_HYST)  next_st.trq_hyst  = st.w_data[15:0];
      end
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // axi read channel
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = 2'b00;
      unique case (s_axi_araddr)
        gain_switch_pkg::OFF_CTRL:      next_st.rdata = {31'h0, st.enable};
        gain_switch_pkg::OFF_POS_MODE:  next_st.rdata = {28'h0, st.pos_mode};
        gain_switch_pkg::OFF_POS_DELAY: next_st.rdata = {16'h0, st.pos_delay};
        gain_switch_pkg::OFF_POS_LEVEL: next_st.rdata = {16'h0, st.pos_level};
        gain_switch_pkg::OFF_POS_HYST:  next_st.rdata = {16'h0, st.pos_hyst};
        gain_switch_pkg::OFF_RAMP_TIME: next_st.rdata = {16'h0, st.ramp_time};
        gain_switch_pkg::OFF_VEL_MODE:  next_st.rdata = {28'h0, st.vel_mode};
        gain_switch_pkg::OFF_VEL_DELAY: next_st.rdata = {16'h0, st.vel_delay};
        gain_switch_pkg::OFF_VEL_LEVEL: next_st.rdata = {16'h0, st.vel_level};
        gain_switch_pkg::OFF_VEL_HYST:  next_st.rdata = {16'h0, st.vel_hyst};
        gain_switch_pkg::OFF_TRQ_MODE:  next_st.rdata = {28'h0, st.trq_mode};
        gain_switch_pkg::OFF_TRQ_DELAY: next_st.rdata = {16'h0, st.trq_delay};
        gain_switch_pkg::OFF_TRQ_LEVEL: next_st.rdata = {16'h0, st.trq_level};
        gain_switch_pkg::OFF_TRQ_HYST:  next_st.rdata = {16'h0, st.trq_hyst};
        gain_switch_pkg::OFF_STATUS:    next_st.rdata = {26'h0, control_loop, 1'b0,
                                                         st.blend != gain_switch_pkg::RAMP_FULL && st.second,
                                                         vel_p_action, st.second};
        default:
        begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = 2'b10;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready   = !st.aw_done;
  assign s_axi_wready    = !st.w_done;
  assign s_axi_bvalid    = st.bvalid;
  assign s_axi_bresp     = st.bresp;
  assign s_axi_arready   = !st.rvalid;
  assign s_axi_rvalid    = st.rvalid;
  assign s_axi_rdata     = st.rdata;
  assign s_axi_rresp     = st.rresp;
  assign use_second_gain = st.second;
  assign vel_p_action    = !st.enable && host_gain_select_bit;
  assign pos_gain_blend  = st.blend;

  a_disabled_first : assert property (@(posedge aclk) disable iff (!aresetn)
    !st.enable |=> !use_second_gain)
    else $error("second gain used while switching disabled");
  a_host_mode_follow : assert property (@(posedge aclk) disable iff (!aresetn)
    st.enable && control_loop == 2'h2 && st.trq_mode == 4'h2 |=> use_second_gain == $past(host_gain_select_bit))
    else $error("host select not followed");
  a_fixed_second : assert property (@(posedge aclk) disable iff (!aresetn)
    st.enable && control_loop == 2'h1 && st.vel_mode == 4'h1 |=> use_second_gain)
    else $error("fixed second gain not applied");
  a_pos_invalid_mode : assert property (@(posedge aclk) disable iff (!aresetn)
    control_loop == 2'h0 && st.pos_mode == 4'h4 |=> !use_second_gain)
    else $error("mode 4 did not fix first gain");
  a_ramp_no_step : assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(use_second_gain) && st.ramp_time > 16'h0001 |-> pos_gain_blend != 16'hffff)
    else $error("position gain stepped despite ramp");
  a_mode_range : assert property (@(posedge aclk) disable iff (!aresetn)
    st.pos_mode <= 4'ha && st.vel_mode <= 4'h5 && st.trq_mode <= 4'h3)
    else $error("switch mode out of range");
  a_trq_force_first : assert property (@(posedge aclk) disable iff (!aresetn)
    control_loop == 2'h2 && st.trq_mode != 4'h3 |=> !trq_trig)
    else $error("torque trigger active outside its mode");
  a_vel_p_action : assert property (@(posedge aclk) disable iff (!aresetn)
    vel_p_action |-> !st.enable && host_gain_select_bit)
    else $error("velocity p action misapplied");

endmodule
`default_nettype wire

// File: test/host_link_model.sv
/*
  host motion controller model: hands the gain select bit to the drive.
  assumes the bench asks for the bit value and picks prompt or slow delivery.
*/
`timescale 1ns/1ps
`default_nettype none
module host_link_model
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic req,
  input  wire logic slow,
  output logic      gain_sel
);
  logic held;
  // slow delivery mimics one extra link cycle of latency
  always_ff @(posedge aclk)
  begin
    held     <= req;
    gain_sel <= !aresetn ? 1'b0 : (slow ? held : req);
  end
endmodule
`default_nettype wire

// File: test/servo_gain_switch_select_tb_top.sv
/*
  self-checking bench for the gain switch select block.
  assumes the design package and the host link model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_gain_switch_select_tb_top;
  localparam int T = gain_switch_pkg::TICK_CYCLES;
  logic        aclk = 1'b0, aresetn = 1'b0, host_req = 1'b0, host_slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pos_cmd_nonzero = 1'b0, in_position = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, torque_cmd_abs = 32'h0, vel_cmd_abs = 32'h0, vel_cmd_var_abs = 32'h0;
  logic [31:0] pos_dev_abs = 32'h0, actual_speed_abs = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  control_loop = 2'h0, s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        host_gain_select_bit, use_second_gain, vel_p_action;
  logic [15:0] pos_gain_blend;
  logic [33:0] exp_q[$], msk_q[$];
  int          failures = 0, total_checks = 0;

  servo_gain_switch_select i_servo_gain_switch_select (.*);
  host_link_model i_host_link_model (.aclk(aclk), .aresetn(aresetn), .req(host_req), .slow(host_slow),
    .gain_sel(host_gain_select_bit));

  initial forever #4 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic bad(input string m);
    failures++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    total_checks++;
    if (s_axi_bresp !== er) bad("write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // status bits: ramping, p action, second gain; settle first
  task automatic st(input logic [2:0] e);
    repeat (20) @(posedge aclk);
    rd(gain_switch_pkg::OFF_STATUS, {31'h0, e}, 34'h7);
    total_checks++;
    if ({pos_gain_blend != 16'hffff && use_second_gain, vel_p_action, use_second_gain} !== e) bad("gain outputs");
  endtask

  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
    begin
      total_checks++;
      if ((({s_axi_rresp, s_axi_rdata} ^ exp_q[0]) & msk_q[0]) !== 34'h0) bad("read value");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6 * T) @(posedge aclk);
    failures++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h9df11212));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(gain_switch_pkg::OFF_CTRL, 34'h0, {34{1'b1}});
    st(3'b000);
    host_req <= 1'b1;
    st(3'b010);
    host_slow <= 1'b1;
    wr(gain_switch_pkg::OFF_POS_MODE, 32'hb, 2'b10);
    wr(gain_switch_pkg::OFF_VEL_MODE, 32'h6, 2'b10);
    wr(gain_switch_pkg::OFF_TRQ_MODE, 32'h4, 2'b10);
    rd(8'h3c, {2'b10, 32'h0}, 34'h3_0000_0000);
    wr(gain_switch_pkg::OFF_CTRL, 32'h1, 2'b00);
    control_loop <= 2'h2;
    for (int m = 0; m < 3; m++)
      for (int h = 0; h < 2; h++)
      begin
        host_req <= h[0];
        wr(gain_switch_pkg::OFF_TRQ_MODE, m, 2'b00);
        st({2'b00, m == 1 || (m == 2 && h == 1)});
      end
    wr(gain_switch_pkg::OFF_TRQ_DELAY, 32'h1, 2'b00);
    wr(gain_switch_pkg::OFF_TRQ_LEVEL, 32'd100, 2'b00);
    wr(gain_switch_pkg::OFF_TRQ_HYST, 32'd10, 2'b00);
    wr(gain_switch_pkg::OFF_TRQ_MODE, 32'h3, 2'b00);
    torque_cmd_abs <= 32'd105;
    st(3'b000);
    torque_cmd_abs <= 32'd111 + $urandom_range(0, 5000);
    vel_cmd_abs    <= $urandom;
    st(3'b001);
    torque_cmd_abs <= 32'd50;
    st(3'b001);
    repeat (3 * T) @(posedge aclk);
    st(3'b000);
    // level below hysteresis: threshold becomes twice the level
    torque_cmd_abs <= 32'd15;
    wr(gain_switch_pkg::OFF_TRQ_LEVEL, 32'd10, 2'b00);
    wr(gain_switch_pkg::OFF_TRQ_HYST, 32'd50, 2'b00);
    st(3'b000);
    torque_cmd_abs <= 32'd25;
    st(3'b001);
    wr(gain_switch_pkg::OFF_VEL_LEVEL, 32'd100, 2'b00);
    wr(gain_switch_pkg::OFF_VEL_MODE, 32'h5, 2'b00);
    control_loop <= 2'h1;
    vel_cmd_abs  <= 32'd200 + $urandom_range(0, 5000);
    st(3'b001);
    vel_cmd_abs <= 32'd0;
    st(3'b000);
    control_loop <= 2'h0;
    wr(gain_switch_pkg::OFF_RAMP_TIME, 32'h4, 2'b00);
    wr(gain_switch_pkg::OFF_POS_MODE, 32'h7, 2'b00);
    st(3'b000);
    pos_cmd_nonzero <= 1'b1;
    st(3'b101);
    pos_cmd_nonzero <= 1'b0;
    st(3'b000);
    repeat (4) @(posedge aclk);
    end_sim();
  end
endmodule
`default_nettype wire
